// ===== verilog/dppr_dram.sv
// dram end: repair mode entry, repair qualification, repair storage
module dppr_dram #(
  parameter int DQ_W    = 8,
  parameter int WL_CYC  = 16,
  parameter int PGM_CYC = dppr_pkg::PGM_X8_CYC
) (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RST,
  dppr_if.dram                               bus,
  input  wire logic [dppr_pkg::BANK_W-1:0]   LOOK_BANK,
  input  wire logic [dppr_pkg::ROW_W-1:0]    LOOK_ROW,
  output logic                               HARD_MODE,
  output logic                               SOFT_MODE,
  output logic                               REPAIR_BUSY,
  output logic [dppr_pkg::NUM_BANKS-1:0]     REF_MASK,
  output logic [dppr_pkg::NUM_BANKS-1:0]     HARD_USED,
  output logic [dppr_pkg::NUM_BANKS-1:0]     SOFT_VALID,
  output logic                               LOOK_HIT,
  output logic                               LOOK_LOST,
  output dppr_pkg::dppr_res_t                RESULT
);
  localparam int NB = dppr_pkg::NUM_BANKS;

  if (WL_CYC < 1 || PGM_CYC < 1 || DQ_W < 1)
  begin : g_check
    $error("dppr_dram: latency, programming count and width must be >= 1");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_KEYS, S_ARMED, S_OPEN, S_WLAT, S_BURST, S_PROG, S_HOLD
  } dppr_dst_t;

  dppr_dst_t                   state;
  dppr_dst_t                   next_state;
  logic [31:0]                 cnt;
  logic [31:0]                 next_cnt;
  logic [1:0]                  idx;
  logic [1:0]                  next_idx;
  dppr_pkg::dppr_res_t         next_res;
  logic                        seed_valid;
  logic                        excl_valid;
  logic [dppr_pkg::BANK_W-1:0] seed_bank;
  logic [dppr_pkg::BANK_W-1:0] excl_bank;
  logic [dppr_pkg::ROW_W-1:0]  seed_row;
  logic                        low_all;
  logic                        high0;
  logic                        high1;
  logic [dppr_pkg::ROW_W-1:0]  hard_row [NB];
  logic [dppr_pkg::ROW_W-1:0]  soft_row [NB];

  // command decode
  wire logic       is_nop    = bus.cmd == dppr_pkg::DPPR_NOP;
  wire logic       is_act    = bus.cmd == dppr_pkg::DPPR_ACT;
  wire logic       is_ref    = bus.cmd == dppr_pkg::DPPR_REF;
  wire logic       is_wr     = bus.cmd == dppr_pkg::DPPR_WR
                               || bus.cmd == dppr_pkg::DPPR_WRA;
  wire logic       is_mrs    = bus.cmd == dppr_pkg::DPPR_MRS;
  wire logic [2:0] mr_sel    = {bus.bg[0], bus.ba};
  wire logic       mr4_wr    = is_mrs && mr_sel == dppr_pkg::MR_SEL_MR4;
  wire logic       key_ok    = is_mrs && mr_sel == dppr_pkg::MR_SEL_MR0
                               && !bus.bg[1]
                               && bus.addr[11:0] == dppr_pkg::dppr_key(idx);
  wire logic       new_hard  = bus.addr[dppr_pkg::MR4_HARD_BIT];
  wire logic       new_soft  = bus.addr[dppr_pkg::MR4_SOFT_BIT];
  wire logic [dppr_pkg::BANK_W-1:0] cmd_bank = {bus.bg, bus.ba};

  // repair qualification
  wire logic beat_low    = ~|bus.dq;
  wire logic beat_high   = &bus.dq;
  wire logic fin_low     = low_all && beat_low;
  wire logic no_res      = HARD_USED[seed_bank];
  wire logic last_beat   = state == S_BURST
                           && idx == 2'(dppr_pkg::BURST_CYC - 1);
  wire logic good        = last_beat && fin_low && !no_res;
  wire logic commit_soft = good && SOFT_MODE;
  wire logic start_hard  = good && HARD_MODE;
  wire logic commit_hard = state == S_PROG && cnt == 32'h0000_0000;

  wire logic [NB-1:0] excl_mask = excl_valid ? NB'(1) << excl_bank
                                             : '0;
  wire logic look_hit  = (HARD_USED[LOOK_BANK]
                          && hard_row[LOOK_BANK] == LOOK_ROW)
                         || (SOFT_VALID[LOOK_BANK]
                          && soft_row[LOOK_BANK] == LOOK_ROW);
  wire logic look_lost = SOFT_MODE && seed_valid
                         && LOOK_BANK[3:1] == seed_bank[3:1]
                         && dppr_pkg::dppr_assoc(LOOK_ROW, seed_row);

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_idx   = idx;
    next_res   = RESULT;
    if (mr4_wr)
    begin
      // both bits at once arms neither mode
      next_idx   = 2'h0;
      next_state = (new_hard ^ new_soft) ? S_KEYS : S_IDLE;
    end
    else
      case (state)
        S_KEYS:
          if (key_ok)
          begin
            next_idx = idx + 2'h1;
            if (idx == 2'h3)
              next_state = S_ARMED;
          end
          else if (!is_nop)
            next_state = S_IDLE;
        S_ARMED:
          if (is_act)
            next_state = S_OPEN;
        S_OPEN:
          if (is_wr && cmd_bank == seed_bank)
          begin
            next_state = S_WLAT;
            next_cnt   = 32'(WL_CYC - 1);
          end
        S_WLAT:
          if (cnt != 32'h0000_0000)
            next_cnt = cnt - 32'h0000_0001;
          else
          begin
            next_state = S_BURST;
            next_idx   = 2'h1;
          end
        S_BURST:
        begin
          next_idx = idx + 2'h1;
          if (last_beat)
          begin
            next_state = start_hard ? S_PROG : S_HOLD;
            next_cnt   = 32'(PGM_CYC - 1);
            if (fin_low && no_res)
              next_res = dppr_pkg::DPPR_RES_IGNORED;
            else if (fin_low && SOFT_MODE)
              next_res = dppr_pkg::DPPR_RES_DONE;
            else if (!fin_low && high0 && high1)
              next_res = dppr_pkg::DPPR_RES_SKIP;
            else if (!fin_low)
              next_res = dppr_pkg::DPPR_RES_UNDEF;
          end
        end
        S_PROG:
          if (cnt != 32'h0000_0000)
            next_cnt = cnt - 32'h0000_0001;
          else
          begin
            next_state = S_HOLD;
            next_res   = dppr_pkg::DPPR_RES_DONE;
          end
        default: ;
      endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state  <= S_IDLE;
      cnt    <= 32'h0000_0000;
      idx    <= 2'h0;
      RESULT <= dppr_pkg::DPPR_RES_NONE;
    end
    else
    begin
      state  <= next_state;
      cnt    <= next_cnt;
      idx    <= next_idx;
      RESULT <= next_res;
    end
  end

  // mode bits, seed capture, burst history
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      HARD_MODE  <= 1'b0;
      SOFT_MODE  <= 1'b0;
      seed_valid <= 1'b0;
      excl_valid <= 1'b0;
      seed_bank  <= '0;
      excl_bank  <= '0;
      seed_row   <= '0;
      low_all    <= 1'b0;
      high0      <= 1'b0;
      high1      <= 1'b0;
    end
    else
    begin
      if (mr4_wr)
      begin
        HARD_MODE  <= new_hard && !new_soft;
        SOFT_MODE  <= new_soft && !new_hard;
        seed_valid <= 1'b0;
        excl_valid <= 1'b0;
      end
      if (state == S_ARMED && is_act)
      begin
        seed_bank  <= cmd_bank;
        seed_row   <= bus.addr;
        seed_valid <= 1'b1;
      end
      if (start_hard)
      begin
        excl_valid <= 1'b1;
        excl_bank  <= seed_bank;
      end
      if (state == S_WLAT && cnt == 32'h0000_0000)
      begin
        low_all <= beat_low;
        high0   <= beat_high;
      end
      if (state == S_BURST)
      begin
        low_all <= fin_low;
        if (idx == 2'(dppr_pkg::HIGH_RUN_CYC - 1))
          high1 <= beat_high;
      end
    end
  end

  // repair resources; reset drops both hard and soft repairs
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      HARD_USED  <= '0;
      SOFT_VALID <= '0;
    end
    else if (commit_soft)
      SOFT_VALID[seed_bank] <= 1'b1;
    else if (commit_hard)
    begin
      HARD_USED[seed_bank]  <= 1'b1;
      SOFT_VALID[seed_bank] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (commit_soft)
      soft_row[seed_bank] <= seed_row;
    if (commit_hard)
      hard_row[seed_bank] <= seed_row;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      REF_MASK    <= '0;
      LOOK_HIT    <= 1'b0;
      LOOK_LOST   <= 1'b0;
      REPAIR_BUSY <= 1'b0;
    end
    else
    begin
      if (is_ref)
        REF_MASK <= ~excl_mask;
      LOOK_HIT    <= look_hit;
      LOOK_LOST   <= look_lost;
      REPAIR_BUSY <= next_state == S_PROG;
    end
  end
endmodule

// ===== verilog/dppr_pkg.sv
// shared constants, types and decode functions for the repair link
package dppr_pkg;
  localparam int CLK_PS       = 5000;
  localparam int PS_PER_MS    = 1_000_000_000;
  localparam int T_PGM_X8_MS  = 1000;
  localparam int T_PGM_X16_MS = 2000;
  localparam int PGM_X8_CYC   = T_PGM_X8_MS * (PS_PER_MS / CLK_PS);
  localparam int PGM_X16_CYC  = T_PGM_X16_MS * (PS_PER_MS / CLK_PS);
  localparam int T_HEXIT_NS   = 15;
  localparam int HEXIT_CYC    = (T_HEXIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_SEXIT_NS   = 20;
  localparam int SEXIT_CYC    = (T_SEXIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_PGMPST_US  = 50;
  localparam int PGMPST_CYC   = (T_PGMPST_US * 1_000_000 + CLK_PS - 1)
                                / CLK_PS;
  localparam int BURST_CYC    = 4;
  localparam int HIGH_RUN_CYC = 2;
  localparam int NUM_BANKS    = 16;
  localparam int BANK_W       = 4;
  localparam int ROW_W        = 18;
  localparam int MR4_HARD_BIT = 13;
  localparam int MR4_SOFT_BIT = 5;
  localparam logic [2:0] MR_SEL_MR0 = 3'h0;
  localparam logic [2:0] MR_SEL_MR4 = 3'h4;
  localparam logic [11:0] KEY_1 = 12'hcff;
  localparam logic [11:0] KEY_2 = 12'h7ff;
  localparam logic [11:0] KEY_3 = 12'hbff;
  localparam logic [11:0] KEY_4 = 12'h3ff;

  typedef enum logic [2:0] {
    DPPR_NOP, DPPR_MRS, DPPR_ACT, DPPR_WR, DPPR_WRA, DPPR_PRE, DPPR_REF
  } dppr_cmd_t;

  typedef enum logic [2:0] {
    DPPR_RES_NONE, DPPR_RES_DONE, DPPR_RES_SKIP, DPPR_RES_UNDEF,
    DPPR_RES_IGNORED
  } dppr_res_t;

  // address bits 11:0 of the guard key with the given index
  function automatic logic [11:0] dppr_key(input logic [1:0] idx);
    logic [11:0] k;
    case (idx)
      2'h0:    k = KEY_1;
      2'h1:    k = KEY_2;
      2'h2:    k = KEY_3;
      default: k = KEY_4;
    endcase
    return k;
  endfunction

  // rows that differ only in bits 17..13, 1 and 0
  function automatic logic dppr_assoc(input logic [ROW_W-1:0] a,
                                      input logic [ROW_W-1:0] b);
    return a[12:2] == b[12:2];
  endfunction
endpackage

// ===== verilog/dppr_if.sv
// command bus and write data between memory controller and dram
interface dppr_if #(parameter int DQ_W = 8);
  dppr_pkg::dppr_cmd_t                    cmd;
  logic [1:0]                             bg;
  logic [1:0]                             ba;
  logic [dppr_pkg::ROW_W-1:0]             addr;
  logic [2*DQ_W-1:0]                      dq;
  logic                                   dq_en;
  modport ctrl (output cmd, bg, ba, addr, dq, dq_en);
  modport dram (input cmd, bg, ba, addr, dq, dq_en);
endinterface

// ===== verilog/dppr_ctrl.sv
// controller end: drives one full repair sequence per request
module dppr_ctrl #(
  parameter int DQ_W       = 8,
  parameter int T_MOD_CYC  = 24,
  parameter int T_RCD_CYC  = 28,
  parameter int WL_CYC     = 16,
  parameter int T_WR_CYC   = 30,
  parameter int T_RP_CYC   = 28,
  parameter int T_REFI_CYC = 1560,
  parameter int PGM_CYC    = dppr_pkg::PGM_X8_CYC,
  parameter int PGMPST_CYC = dppr_pkg::PGMPST_CYC
) (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RST,
  dppr_if.ctrl                               bus,
  input  wire logic                          START,
  input  wire logic                          HARD,
  input  wire logic                          USE_WRA,
  input  wire logic [dppr_pkg::BANK_W-1:0]   BANK,
  input  wire logic [dppr_pkg::ROW_W-1:0]    ROW,
  input  wire logic                          SKIP,
  input  wire logic [dppr_pkg::ROW_W-1:0]    MR0_RESTORE,
  output logic                               BUSY,
  output logic                               DONE
);
  if (T_MOD_CYC < 1 || T_RCD_CYC < 1 || WL_CYC < 1 || T_WR_CYC < 1
      || T_RP_CYC < 1 || T_REFI_CYC < 4 || PGM_CYC < 1 || PGMPST_CYC < 1)
  begin : g_check
    $error("dppr_ctrl: timing counts too small");
  end

  typedef enum logic [3:0] {
    C_IDLE, C_MR4, C_KEY, C_ACT, C_WR, C_DATA, C_PGM, C_PEXIT, C_PST,
    C_TAIL
  } dppr_cst_t;

  dppr_cst_t                   state;
  dppr_cst_t                   next_state;
  logic [31:0]                 cnt;
  logic [31:0]                 next_cnt;
  logic [31:0]                 rcnt;
  logic [1:0]                  idx;
  logic [1:0]                  next_idx;
  logic                        op_hard;
  logic                        op_wra;
  logic                        op_skip;
  logic [dppr_pkg::BANK_W-1:0] op_bank;
  logic [dppr_pkg::ROW_W-1:0]  op_row;
  logic [dppr_pkg::ROW_W-1:0]  op_mr0;
  dppr_pkg::dppr_cmd_t         next_cmd;
  logic [1:0]                  next_bg;
  logic [1:0]                  next_ba;
  logic [dppr_pkg::ROW_W-1:0]  next_addr;
  logic [2*DQ_W-1:0]           next_dq;
  logic                        next_en;

  wire logic cnt_zero  = cnt == 32'h0000_0000;
  wire logic last_beat = state == C_DATA && cnt_zero && idx == 2'h3;
  wire logic ref_due   = state == C_PGM && !cnt_zero && op_hard && op_wra
                         && rcnt == 32'h0000_0000;

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt_zero ? cnt : cnt - 32'h0000_0001;
    next_idx   = idx;
    next_cmd   = dppr_pkg::DPPR_NOP;
    next_bg    = 2'h0;
    next_ba    = 2'h0;
    next_addr  = '0;
    next_dq    = '0;
    next_en    = 1'b0;
    case (state)
      C_IDLE:
        if (START)
          next_state = C_MR4;
      C_MR4:
      begin
        next_cmd   = dppr_pkg::DPPR_MRS;
        next_bg    = 2'h1;
        next_addr[dppr_pkg::MR4_HARD_BIT] = op_hard;
        next_addr[dppr_pkg::MR4_SOFT_BIT] = !op_hard;
        next_state = C_KEY;
        next_cnt   = 32'(T_MOD_CYC - 1);
        next_idx   = 2'h0;
      end
      C_KEY:
        if (cnt_zero)
        begin
          next_cmd        = dppr_pkg::DPPR_MRS;
          next_addr[11:0] = dppr_pkg::dppr_key(idx);
          next_idx        = idx + 2'h1;
          next_cnt        = 32'(T_MOD_CYC - 1);
          if (idx == 2'h3)
            next_state = C_ACT;
        end
      C_ACT:
        if (cnt_zero)
        begin
          next_cmd   = dppr_pkg::DPPR_ACT;
          {next_bg, next_ba} = op_bank;
          next_addr  = op_row;
          next_state = C_WR;
          next_cnt   = 32'(T_RCD_CYC - 1);
        end
      C_WR:
        if (cnt_zero)
        begin
          next_cmd   = (op_hard && op_wra) ? dppr_pkg::DPPR_WRA
                                           : dppr_pkg::DPPR_WR;
          {next_bg, next_ba} = op_bank;
          next_state = C_DATA;
          next_cnt   = 32'(WL_CYC - 1);
          next_idx   = 2'h0;
        end
      C_DATA:
        if (cnt_zero)
        begin
          next_en  = 1'b1;
          next_dq  = op_skip ? '1 : '0;
          next_idx = idx + 2'h1;
          if (idx == 2'h3)
          begin
            next_state = C_PGM;
            next_cnt   = op_hard ? 32'(PGM_CYC) : 32'(T_WR_CYC);
          end
        end
      C_PGM:
        if (cnt_zero)
        begin
          next_cmd   = dppr_pkg::DPPR_PRE;
          {next_bg, next_ba} = op_bank;
          next_state = C_PEXIT;
          next_cnt   = op_hard ? 32'(dppr_pkg::HEXIT_CYC - 1)
                               : 32'(dppr_pkg::SEXIT_CYC - 1);
        end
        else if (ref_due)
          next_cmd = dppr_pkg::DPPR_REF;
      C_PEXIT:
        if (cnt_zero)
        begin
          next_cmd   = dppr_pkg::DPPR_MRS;
          next_bg    = 2'h1;
          next_state = C_PST;
          next_cnt   = op_hard ? 32'(PGMPST_CYC - 1)
                               : 32'(T_MOD_CYC - 1);
        end
      C_PST:
        if (cnt_zero)
        begin
          next_cmd   = dppr_pkg::DPPR_MRS;
          next_addr  = op_mr0;
          next_state = C_TAIL;
          next_cnt   = 32'(T_MOD_CYC - 1);
        end
      C_TAIL:
        if (cnt_zero)
          next_state = C_IDLE;
      default:
        next_state = C_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state     <= C_IDLE;
      cnt       <= 32'h0000_0000;
      idx       <= 2'h0;
      bus.cmd   <= dppr_pkg::DPPR_NOP;
      bus.bg    <= 2'h0;
      bus.ba    <= 2'h0;
      bus.addr  <= '0;
      bus.dq    <= '0;
      bus.dq_en <= 1'b0;
      BUSY      <= 1'b0;
      DONE      <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      idx       <= next_idx;
      bus.cmd   <= next_cmd;
      bus.bg    <= next_bg;
      bus.ba    <= next_ba;
      bus.addr  <= next_addr;
      bus.dq    <= next_dq;
      bus.dq_en <= next_en;
      BUSY      <= next_state != C_IDLE;
      DONE      <= state == C_TAIL && cnt_zero;
    end
  end

  // refresh pacing inside the programming wait
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      rcnt <= 32'h0000_0000;
    else if (last_beat)
      rcnt <= 32'(T_WR_CYC + T_RP_CYC);
    else if (ref_due)
      rcnt <= 32'(T_REFI_CYC - 1);
    else if (rcnt != 32'h0000_0000)
      rcnt <= rcnt - 32'h0000_0001;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      op_hard <= 1'b0;
      op_wra  <= 1'b0;
      op_skip <= 1'b0;
      op_bank <= '0;
      op_row  <= '0;
      op_mr0  <= '0;
    end
    else if (state == C_IDLE && START)
    begin
      op_hard <= HARD;
      op_wra  <= USE_WRA;
      op_skip <= SKIP;
      op_bank <= BANK;
      op_row  <= ROW;
      op_mr0  <= MR0_RESTORE;
    end
  end
endmodule

// ===== dv/dppr_monitor.sv
// wire-level checks of the repair command sequence on the link
module dppr_monitor #(
  parameter int DQ_W       = 8,
  parameter int WL_CYC     = 16,
  parameter int T_MOD_CYC  = 24,
  parameter int T_RCD_CYC  = 28,
  parameter int T_WR_CYC   = 30,
  parameter int T_RP_CYC   = 28,
  parameter int T_REFI_CYC = 8,
  parameter int PGM_CYC    = 100,
  parameter int PGMPST_CYC = 20
) (
  input wire logic                       CORE_CLK,
  input wire logic                       RST,
  input wire dppr_pkg::dppr_cmd_t        cmd,
  input wire logic [1:0]                 bg,
  input wire logic [1:0]                 ba,
  input wire logic [dppr_pkg::ROW_W-1:0] addr,
  input wire logic [2*DQ_W-1:0]          dq,
  input wire logic                       dq_en
);
  logic [15:0] gap;
  logic [15:0] since_wr;
  logic [15:0] ref_gap;
  logic [3:0]  act_bank;
  logic        hard_m;
  logic        last_clr;
  logic        last_mrs;
  logic        last_wra;
  wire         any_cmd = cmd != dppr_pkg::DPPR_NOP;
  wire         is_mrs  = cmd == dppr_pkg::DPPR_MRS;
  wire         is_ref  = cmd == dppr_pkg::DPPR_REF;
  wire         is_pre  = cmd == dppr_pkg::DPPR_PRE;
  wire         is_act  = cmd == dppr_pkg::DPPR_ACT;
  wire         is_wra  = cmd == dppr_pkg::DPPR_WRA;
  wire         is_wr   = is_wra || cmd == dppr_pkg::DPPR_WR;
  wire         is_mr4  = is_mrs && {bg[0], ba} == dppr_pkg::MR_SEL_MR4;
  wire         is_mr0  = is_mrs && {bg[0], ba} == dppr_pkg::MR_SEL_MR0;

  // saturating cycle counters since the last command, write and refresh
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      gap <= 16'h0000;
      since_wr <= 16'hffff;
      ref_gap <= 16'hffff;
      act_bank <= 4'h0;
      hard_m <= 1'b0;
      last_clr <= 1'b0;
      last_mrs <= 1'b0;
      last_wra <= 1'b0;
    end
    else
    begin
      gap <= any_cmd ? 16'h0000 : gap + {15'h0000, gap != 16'hffff};
      since_wr <= is_wr ? 16'h0000 : since_wr + {15'h0000, ~&since_wr};
      ref_gap <= is_ref ? 16'h0000 : ref_gap + {15'h0000, ~&ref_gap};
      act_bank <= is_act ? {bg, ba} : act_bank;
      hard_m <= (is_mr4 && addr != '0) ? addr[13] : hard_m;
      last_clr <= any_cmd ? is_mr4 && addr == '0 : last_clr;
      last_mrs <= any_cmd ? is_mrs : last_mrs;
      last_wra <= is_wr ? is_wra : last_wra;
    end
  end

  default clocking mon_cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  key_spacing_a: assert property (
    any_cmd && last_mrs && !last_clr |-> gap >= T_MOD_CYC - 1)
    else $error("command too soon after mode write");
  act_write_a: assert property (
    is_act |-> ##T_RCD_CYC is_wr && {bg, ba} == act_bank)
    else $error("write missing or to wrong bank");
  burst_len_a: assert property (
    is_wr |-> ##WL_CYC dq_en [*4] ##1 !dq_en)
    else $error("data burst misplaced");
  burst_level_a: assert property (
    dq_en |-> dq == '0 || dq == '1)
    else $error("mixed data in burst");
  ref_start_a: assert property (
    is_ref |-> hard_m && last_wra
      && since_wr >= WL_CYC + 3 + T_WR_CYC + T_RP_CYC)
    else $error("refresh not allowed here");
  ref_space_a: assert property (
    is_ref |-> ref_gap >= T_REFI_CYC / 4 - 1)
    else $error("refreshes too close");
  pgm_time_a: assert property (
    is_pre && hard_m |-> since_wr >= WL_CYC + 3 + PGM_CYC)
    else $error("precharge before programming time");
  pre_exit_a: assert property (
    is_pre |=> !any_cmd [*2])
    else $error("command too soon after precharge");
  exit_wait_a: assert property (
    any_cmd && last_clr && hard_m |-> gap >= PGMPST_CYC - 1)
    else $error("command too soon after hard exit");
  mr0_restore_a: assert property (
    any_cmd && last_clr |-> is_mr0)
    else $error("mode register zero not restored");
  one_mode_a: assert property (
    is_mr4 |-> !(addr[13] && addr[5]))
    else $error("both repair modes enabled");
endmodule

// ===== dv/dppr_bench.sv
// self-checking bench: controller and dram joined over the repair link
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
  end

module dppr_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PGM  = 100;
  localparam int PST  = 20;
  localparam int REFI = 8;
  logic                core_clk;
  logic                rst;
  logic                start, hard, use_wra, skip;
  logic [3:0]          bank, look_bank;
  logic [17:0]         row, mr0, look_row;
  logic                busy, done, hard_mode, soft_mode, hit, lost, rbusy;
  logic [15:0]         ref_mask, hard_used, soft_valid;
  dppr_pkg::dppr_res_t result;
  int                  err_count, num_checks, cycles, tnum;
  logic [15:0]         hu, sv;
  logic [17:0]         hrow [16];
  logic [17:0]         srow [16];

  dppr_if dppr_if_i ();
  dppr_ctrl #(.PGM_CYC(PGM), .PGMPST_CYC(PST), .T_REFI_CYC(REFI))
  dppr_ctrl_i (
    .CORE_CLK(core_clk), .RST(rst), .bus(dppr_if_i), .START(start),
    .HARD(hard), .USE_WRA(use_wra), .BANK(bank), .ROW(row), .SKIP(skip),
    .MR0_RESTORE(mr0), .BUSY(busy), .DONE(done));
  dppr_dram #(.PGM_CYC(PGM)) dppr_dram_i (
    .CORE_CLK(core_clk), .RST(rst), .bus(dppr_if_i),
    .LOOK_BANK(look_bank), .LOOK_ROW(look_row), .HARD_MODE(hard_mode),
    .SOFT_MODE(soft_mode), .REPAIR_BUSY(rbusy), .REF_MASK(ref_mask),
    .HARD_USED(hard_used), .SOFT_VALID(soft_valid), .LOOK_HIT(hit),
    .LOOK_LOST(lost), .RESULT(result));
  dppr_monitor #(.PGM_CYC(PGM), .PGMPST_CYC(PST), .T_REFI_CYC(REFI))
  dppr_monitor_i (
    .CORE_CLK(core_clk), .RST(rst), .cmd(dppr_if_i.cmd),
    .bg(dppr_if_i.bg), .ba(dppr_if_i.ba), .addr(dppr_if_i.addr),
    .dq(dppr_if_i.dq), .dq_en(dppr_if_i.dq_en));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      test_done();
    end
  end

  function automatic logic exp_hit(logic [3:0] b, logic [17:0] r);
    return (hu[b] && hrow[b] == r) || (sv[b] && srow[b] == r);
  endfunction

  // query the row lookup and compare with the repair model
  task automatic look(input logic [3:0] b, input logic [17:0] r);
    @(posedge core_clk);
    look_bank <= b;
    look_row <= r;
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK("hit", exp_hit(b, r), hit)
  endtask

  // one full repair sequence through the controller
  task automatic run(input logic h, w, input logic [3:0] b,
                     input logic [17:0] r, input logic s);
    dppr_pkg::dppr_res_t er;
    logic [15:0]         em;
    int                  n;
    int                  nb;
    er = s ? dppr_pkg::DPPR_RES_SKIP : dppr_pkg::DPPR_RES_DONE;
    // an all-high burst is a skip even on a used bank
    er = (hu[b] && !s) ? dppr_pkg::DPPR_RES_IGNORED : er;
    em = (s || hu[b]) ? 16'hffff : ~(16'h0001 << b);
    @(posedge core_clk);
    start <= 1'b1;
    hard <= h;
    use_wra <= w;
    bank <= b;
    row <= r;
    skip <= s;
    mr0 <= 18'($urandom);
    look_bank <= b ^ 4'h1;
    look_row <= r ^ 18'h3_e003;
    @(posedge core_clk);
    start <= 1'b0;
    n = 0;
    nb = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge core_clk);
      n++;
      nb += (rbusy === 1'b1) ? 1 : 0;
      `CHK("busy", !done, busy)
      if (dppr_if_i.cmd === dppr_pkg::DPPR_PRE && !hu[b])
      begin
        `CHK("lost", !h, lost)
        `CHK("mode", {h, !h}, {hard_mode, soft_mode})
      end
    end
    `CHK("done", 1'b1, done)
    `CHK("result", er, result)
    `CHK("pgm", (h && !s && !hu[b]) ? PGM : 0, nb)
    if (h && w)
      `CHK("refmask", em, ref_mask)
    if (!hu[b] && !s)
    begin
      hu[b] = h;
      sv[b] = !h;
      hrow[b] = r;
      srow[b] = r;
    end
    `CHK("used", hu, hard_used)
    `CHK("soft", sv, soft_valid)
    look(b, r);
    tnum++;
    $display("test %0d end", tnum);
  endtask

  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    hard = 1'b0;
    use_wra = 1'b0;
    skip = 1'b0;
    bank = 4'h0;
    row = 18'h0_0000;
    mr0 = 18'h0_0000;
    look_bank = 4'h0;
    look_row = 18'h0_0000;
    hu = 16'h0000;
    sv = 16'h0000;
    cycles = 0;
    tnum = 0;
    err_count = 0;
    num_checks = 0;
    void'($urandom(32'h0000_0bb9));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `CHK("res0", dppr_pkg::DPPR_RES_NONE, result)
    run(1'b1, 1'b0, 4'h0, 18'h0_0123, 1'b1);
    run(1'b1, 1'b1, 4'hf, 18'h3_ffff, 1'b0);
    run(1'b1, 1'b1, 4'h2, 18'h0_0777, 1'b1);
    run(1'b0, 1'b0, 4'h3, 18'h0_0004, 1'b0);
    run(1'b0, 1'b0, 4'h3, 18'h2_8000, 1'b0);
    look(4'h3, 18'h0_0004);
    run(1'b1, 1'b0, 4'h3, 18'h1_0001, 1'b0);
    run(1'b0, 1'b0, 4'hf, 18'h0_1111, 1'b0);
    run(1'b1, 1'b1, 4'hf, 18'h0_2222, 1'b0);
    repeat (10)
      run(1'($urandom), 1'($urandom), 4'($urandom), 18'($urandom),
          1'($urandom_range(3) == 0));
    run(1'b0, 1'b0, 4'h6, 18'h0_0abc, 1'b0);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `CHK("soft_rst", 16'h0000, soft_valid)
    hu = 16'h0000;
    sv = 16'h0000;
    look(4'h6, 18'h0_0abc);
    test_done();
  end
endmodule
